// >>> dv/epsia_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import epsia_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, dest_file;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [ADDR_W-1:0] eff_addr;
  logic [PC_W-1:0] pc;
  int errors, samples_checked;

  epsia_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eff_addr(eff_addr), .dest_file(dest_file), .pc(pc));

  initial begin
    pclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; leaves psel up for a back-to-back setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask : apb

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    idle;
  endtask : reg_rd

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      reg_rd(OFF_STATUS);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 20);
    chk({31'h0, rd[ST_BUSY_BIT]}, 32'h0, "busy");
  endtask : wait_idle

  task automatic exec_op(input logic [15:0] op);
    reg_wr(OFF_INSTR, {16'h0, op});
    wait_idle;
  endtask : exec_op

  task automatic t_reset;
    reg_rd(OFF_CTRL);
    chk(rd, 32'h0, "ctrl reset");
    reg_rd(OFF_STATUS);
    chk(rd, 32'h0, "status reset");
    chk({11'h0, pc}, 32'h0, "pc reset");
    reg_rd(8'h3c);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped");
  endtask : t_reset

  task automatic t_subtract_literal_from_pointer;
    logic [11:0] v[3] = '{12'h005, 12'h040, 12'h3ff};
    logic [5:0] k[3] = '{6'h3f, 6'h00, 6'h23};
    reg_wr(OFF_CTRL, 32'h1);
    reg_wr(OFF_PC, 32'h100);
    for (int s = 0; s < 3; s++) begin
      reg_wr(OFF_PTR0 + 8'(4 * s), {20'h0, v[s]});
      exec_op({SUB_OPC, 2'(s), k[s]});
      reg_rd(OFF_PTR0 + 8'(4 * s));
      chk(rd, {20'h0, v[s] - 12'(k[s])}, "pointer subtract");
    end
    chk({11'h0, pc}, 32'h106, "pc after subtract");
  endtask : t_subtract_literal_from_pointer

  task automatic t_return;
    int n;
    n = 0;
    reg_wr(OFF_FRAME, 32'h3ff);
    reg_wr(OFF_TOS, 32'h1234);
    reg_wr(OFF_INSTR, 32'he9e3);
    while (pc !== 21'h1234 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk({11'h0, pc}, 32'h1234, "return pc");
    apb(1'b0, OFF_STATUS, 32'h0);
    idle;
    chk({30'h0, rd[1:0]}, 32'h3, "second cycle busy");
    reg_rd(OFF_STATUS);
    chk({31'h0, rd[ST_BUSY_BIT]}, 32'h0, "busy released");
    reg_rd(OFF_FRAME);
    chk(rd, 32'h3dc, "frame after return");
  endtask : t_return

  task automatic t_disabled;
    reg_wr(OFF_CTRL, 32'h0);
    reg_wr(OFF_FRAME, 32'h100);
    reg_wr(OFF_PC, 32'h200);
    exec_op(16'he9c5);
    reg_rd(OFF_FRAME);
    chk(rd, 32'h100, "frame untouched");
    chk({11'h0, pc}, 32'h202, "pc no return");
    reg_rd(OFF_STATUS);
    chk({28'h0, rd[3:0]}, 32'h8, "disabled flag");
  endtask : t_disabled

  task automatic t_refused;
    reg_wr(OFF_CTRL, 32'h1);
    reg_wr(OFF_PTR0, 32'h010);
    reg_wr(OFF_PTR1, 32'h020);
    apb(1'b1, OFF_INSTR, 32'he901);
    apb(1'b1, OFF_INSTR, 32'he941);
    idle;
    chk({31'h0, err}, 32'h1, "refused issue");
    wait_idle;
    reg_rd(OFF_PTR0);
    chk(rd, 32'h00f, "first op");
    reg_rd(OFF_PTR1);
    chk(rd, 32'h020, "second op dropped");
    chk({31'h0, err}, 32'h0, "pointer read error");
    reg_rd(OFF_STATUS);
    chk({31'h0, rd[ST_REFUSED_BIT]}, 32'h1, "refused flag");
  endtask : t_refused

  task automatic t_addr(input logic ext, input logic [3:0] bk, input logic [11:0] fr,
      input logic [15:0] op, input logic [11:0] ea, input logic d, input logic ix);
    reg_wr(OFF_CTRL, {31'h0, ext});
    reg_wr(OFF_BANK, {28'h0, bk});
    reg_wr(OFF_FRAME, {20'h0, fr});
    exec_op(op);
    chk({19'h0, dest_file, eff_addr}, {19'h0, d, ea}, "addr port");
    reg_rd(OFF_EADDR);
    chk(rd, {18'h0, ix, d, ea}, "addr register");
  endtask : t_addr

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_subtract_literal_from_pointer;
    t_return;
    t_disabled;
    t_refused;
    t_addr(1'b0, 4'h0, 12'ha00, 16'h2620, 12'h020, 1'b1, 1'b0);
    t_addr(1'b0, 4'h5, 12'ha00, 16'h2520, 12'h520, 1'b0, 1'b0);
    t_addr(1'b0, 4'h5, 12'ha00, 16'h2680, 12'hf80, 1'b1, 1'b0);
    t_addr(1'b1, 4'h5, 12'ha00, 16'h242c, 12'ha2c, 1'b0, 1'b1);
    t_addr(1'b1, 4'h5, 12'ha00, 16'h265f, 12'ha5f, 1'b1, 1'b1);
    t_addr(1'b1, 4'h5, 12'ha00, 16'h2660, 12'hf60, 1'b1, 1'b0);
    t_addr(1'b1, 4'h3, 12'ha00, 16'h2710, 12'h310, 1'b1, 1'b0);
    t_addr(1'b1, 4'h3, 12'h000, 16'h2630, 12'h030, 1'b1, 1'b1);
    t_addr(1'b1, 4'h3, 12'hfe0, 16'h2640, 12'h020, 1'b1, 1'b1);
    t_addr(1'b1, 4'h3, 12'ha00, 16'h8e0a, 12'ha0a, 1'b1, 1'b1);
    report_and_stop;
  end

  // Cuts a hang short
  initial begin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    report_and_stop;
  end

  task automatic report_and_stop;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
endmodule : testbench
`default_nettype wire

// >>> src/epsia_addr_gen.sv
`timescale 1ns/100ps
`default_nettype none
module epsia_addr_gen (
  epsia_addr_if.gen a
);
  import epsia_pkg::*;
  logic [7:0] f;
  logic [3:0] grp;
  always_comb begin
    f = a.opcode[7:0];
    grp = a.opcode[15:12];
    // Byte and bit oriented groups carry the access bit
    a.has_access = (grp >= 4'h1 && grp <= 4'hb) || a.opcode[15:10] == 6'h01 ||
      a.opcode[15:9] == 7'h01;
    a.has_dest = (grp >= 4'h1 && grp <= 4'h5) || a.opcode[15:10] == 6'h01;
    a.dest_file = a.has_dest ? a.opcode[9] : 1'b1;
    a.indexed = a.has_access && !a.opcode[8] && a.ext_en && f <= IDX_LIMIT;
    if (!a.has_access) begin
      a.eff_addr = 12'h000;
    end else if (a.opcode[8]) begin
      a.eff_addr = {a.bank, f};
    end else if (a.indexed) begin
      a.eff_addr = a.frame + {4'h0, f};
    end else if (f > IDX_LIMIT) begin
      a.eff_addr = {ACC_HI_BANK, f};
    end else begin
      a.eff_addr = {ACC_LO_BANK, f};
    end
  end
endmodule : epsia_addr_gen
`default_nettype wire

// >>> src/epsia_addr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface epsia_addr_if;
  logic [15:0] opcode;
  logic ext_en;
  logic [11:0] frame;
  logic [3:0] bank;
  logic [11:0] eff_addr;
  logic indexed;
  logic has_access;
  logic has_dest;
  logic dest_file;
  modport gen (input opcode, ext_en, frame, bank,
    output eff_addr, indexed, has_access, has_dest, dest_file);
  modport user (output opcode, ext_en, frame, bank,
    input eff_addr, indexed, has_access, has_dest, dest_file);
endinterface : epsia_addr_if
`default_nettype wire

// >>> src/epsia_pkg.sv
package epsia_pkg;
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam int CLK_PERIOD_NS = 100;
  localparam int INSTR_CYCLE_NS = 400;
  localparam int Q_PHASES = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [1:0] Q_LAST = 2'(Q_PHASES - 1);

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_PTR0 = 8'h08;
  localparam logic [7:0] OFF_PTR1 = 8'h0c;
  localparam logic [7:0] OFF_FRAME = 8'h10;
  localparam logic [7:0] OFF_BANK = 8'h14;
  localparam logic [7:0] OFF_TOS = 8'h18;
  localparam logic [7:0] OFF_PC = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_EADDR = 8'h24;

  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EXT_OP_BIT = 1;
  localparam int ST_IDX_BIT = 2;
  localparam int ST_DISABLED_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int EA_DEST_BIT = 12;
  localparam int EA_IDX_BIT = 13;

  localparam logic [7:0] SUB_OPC = 8'he9;
  localparam logic [1:0] RET_SEL = 2'h3;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;

  localparam logic [11:0] PTR_RST = 12'h000;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [20:0] PC_RST = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [15:0] OPC_RST = 16'h0000;
  localparam logic EXT_RST = 1'b0;

  typedef enum logic [2:0] {
    EPSIA_IDLE = 3'b001,
    EPSIA_EXEC = 3'b010,
    EPSIA_NOP = 3'b100
  } epsia_state_t;
endpackage : epsia_pkg

// >>> src/epsia_top.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module epsia_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [epsia_pkg::ADDR_W-1:0] eff_addr,
  output logic dest_file,
  output logic [epsia_pkg::PC_W-1:0] pc
);
  import epsia_pkg::*;

  typedef struct packed {
    epsia_state_t st;
    logic [1:0] qcnt;
    logic ext_en;
    logic [15:0] opcode;
    logic [2:0][11:0] ptr;
    logic [3:0] bank;
    logic [20:0] top_of_return_stack;
    logic [20:0] pc;
    logic [11:0] eaddr;
    logic dest_file;
    logic idx_used;
    logic ext_op;
    logic disabled_op;
    logic refused;
    logic [31:0] prdata;
    logic pslverr;
  } epsia_regs_t;

  localparam epsia_regs_t REGS_RST = '{
    st: EPSIA_IDLE,
    qcnt: 2'h0,
    ext_en: EXT_RST,
    opcode: OPC_RST,
    ptr: {PTR_RST, PTR_RST, PTR_RST},
    bank: BANK_RST,
    top_of_return_stack: PC_RST,
    pc: PC_RST,
    eaddr: PTR_RST,
    dest_file: 1'b0,
    idx_used: 1'b0,
    ext_op: 1'b0,
    disabled_op: 1'b0,
    refused: 1'b0,
    prdata: 32'h00000000,
    pslverr: 1'b0
  };

  epsia_regs_t r;
  epsia_regs_t next_r;
  logic setup;
  logic access_wr;
  logic q4;
  logic fire;
  logic is_sub;
  logic is_ret;
  logic [1:0] sel;
  logic [11:0] lit;

  epsia_addr_if a ();

  epsia_addr_gen u_addr (
    .a(a)
  );

  assign a.opcode = r.opcode;
  assign a.ext_en = r.ext_en;
  assign a.frame = r.ptr[2];
  assign a.bank = r.bank;

  assign setup = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  // End of the four-phase instruction cycle
  assign q4 = r.qcnt == Q_LAST;
  assign fire = r.st == EPSIA_EXEC && q4;
  assign sel = r.opcode[7:6];
  assign lit = {6'h00, r.opcode[5:0]};
  assign is_sub = r.ext_en && r.opcode[15:8] == SUB_OPC;
  assign is_ret = is_sub && sel == RET_SEL;

  always_comb begin
    next_r = r;
    next_r.qcnt = r.qcnt + 2'h1;
    // Read data and error are decided in the setup phase
    if (setup) begin
      next_r.prdata = 32'h00000000;
      next_r.pslverr = 1'b0;
      case (paddr)
        OFF_CTRL: begin
          next_r.prdata[CTRL_EXT_BIT] = r.ext_en;
        end
        OFF_INSTR: begin
          next_r.prdata = {16'h0000, r.opcode};
          next_r.pslverr = pwrite && r.st != EPSIA_IDLE;
        end
        OFF_PTR0: begin
          next_r.prdata = {20'h00000, r.ptr[0]};
        end
        OFF_PTR1: begin
          next_r.prdata = {20'h00000, r.ptr[1]};
        end
        OFF_FRAME: begin
          next_r.prdata = {20'h00000, r.ptr[2]};
        end
        OFF_BANK: begin
          next_r.prdata = {28'h0000000, r.bank};
        end
        OFF_TOS: begin
          next_r.prdata = {11'h000, r.top_of_return_stack};
        end
        OFF_PC: begin
          next_r.prdata = {11'h000, r.pc};
        end
        OFF_STATUS: begin
          next_r.prdata[ST_BUSY_BIT] = r.st != EPSIA_IDLE;
          next_r.prdata[ST_EXT_OP_BIT] = r.ext_op;
          next_r.prdata[ST_IDX_BIT] = r.idx_used;
          next_r.prdata[ST_DISABLED_BIT] = r.disabled_op;
          next_r.prdata[ST_REFUSED_BIT] = r.refused;
        end
        OFF_EADDR: begin
          next_r.prdata[11:0] = r.eaddr;
          next_r.prdata[EA_DEST_BIT] = r.dest_file;
          next_r.prdata[EA_IDX_BIT] = r.idx_used;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    if (access_wr && !r.pslverr) begin
      case (paddr)
        OFF_CTRL: begin
          next_r.ext_en = pwdata[CTRL_EXT_BIT];
        end
        OFF_INSTR: begin
          next_r.opcode = pwdata[15:0];
          next_r.st = EPSIA_EXEC;
          next_r.refused = 1'b0;
        end
        OFF_PTR0: begin
          next_r.ptr[0] = pwdata[11:0];
        end
        OFF_PTR1: begin
          next_r.ptr[1] = pwdata[11:0];
        end
        OFF_FRAME: begin
          next_r.ptr[2] = pwdata[11:0];
        end
        OFF_BANK: begin
          next_r.bank = pwdata[3:0];
        end
        OFF_TOS: begin
          next_r.top_of_return_stack = pwdata[20:0];
        end
        OFF_PC: begin
          next_r.pc = pwdata[20:0];
        end
        default: begin
        end
      endcase
    end
    // Issue while busy is dropped and remembered
    if (access_wr && r.pslverr && paddr == OFF_INSTR) begin
      next_r.refused = 1'b1;
    end
    // Execution overrides a software write in the same cycle
    case (r.st)
      EPSIA_IDLE: begin
      end
      EPSIA_EXEC: begin
        if (q4) begin
          next_r.st = EPSIA_IDLE;
          next_r.ext_op = is_sub;
          next_r.disabled_op = !r.ext_en && r.opcode[15:8] == SUB_OPC;
          next_r.pc = r.pc + PC_STEP;
          if (is_ret) begin
            next_r.ptr[2] = r.ptr[2] - lit;
            next_r.pc = r.top_of_return_stack;
            next_r.st = EPSIA_NOP;
          end else if (is_sub) begin
            next_r.ptr[sel] = r.ptr[sel] - lit;
          end else if (a.has_access) begin
            next_r.eaddr = a.eff_addr;
            next_r.dest_file = a.dest_file;
            next_r.idx_used = a.indexed;
          end
        end
      end
      EPSIA_NOP: begin
        if (q4) begin
          next_r.st = EPSIA_IDLE;
        end
      end
      default: begin
        next_r.st = EPSIA_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = r.pslverr;
  assign eff_addr = r.eaddr;
  assign dest_file = r.dest_file;
  assign pc = r.pc;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ptr_subtract: assert property (
    fire && is_sub && !is_ret |=> r.ptr[$past(sel)] == $past(r.ptr[sel]) - $past(lit)
  ) else $error("pointer subtract result wrong");

  chk_ret_loads_pc: assert property (
    fire && is_ret |=> r.pc == $past(r.top_of_return_stack)
  ) else $error("return did not load pc from stack top");

  chk_ret_two_cycles: assert property (
    fire && is_ret |=> (r.st == EPSIA_NOP) [*4] ##1 r.st == EPSIA_IDLE
  ) else $error("subtract-and-return not two instruction cycles");

  chk_ret_frame_only: assert property (
    fire && is_ret |=> r.ptr[2] == $past(r.ptr[2]) - $past(lit) &&
      r.ptr[0] == $past(r.ptr[0]) && r.ptr[1] == $past(r.ptr[1])
  ) else $error("subtract-and-return touched wrong pointer");

  chk_ext_disabled: assert property (
    fire && !r.ext_en && r.opcode[15:8] == SUB_OPC |=> r.ptr == $past(r.ptr) &&
      r.pc == $past(r.pc) + PC_STEP && r.disabled_op
  ) else $error("extended opcode acted while disabled");

  chk_indexed_addr: assert property (
    a.has_access && !r.opcode[8] && r.ext_en && r.opcode[7:0] <= IDX_LIMIT |->
      a.indexed && a.eff_addr == r.ptr[2] + {4'h0, r.opcode[7:0]}
  ) else $error("indexed address not frame plus offset");

  chk_high_literal: assert property (
    a.has_access && !r.opcode[8] && r.opcode[7:0] > IDX_LIMIT |->
      !a.indexed && a.eff_addr == {ACC_HI_BANK, r.opcode[7:0]}
  ) else $error("high access bank address remapped");

  chk_literal_mode: assert property (
    a.has_access && !r.ext_en |-> !a.indexed &&
      a.eff_addr == (r.opcode[8] ? {r.bank, r.opcode[7:0]} :
      {(r.opcode[7:0] > IDX_LIMIT) ? ACC_HI_BANK : ACC_LO_BANK, r.opcode[7:0]})
  ) else $error("literal address wrong with extension off");

  chk_frame_zero: assert property (
    a.has_access && !r.opcode[8] && r.ptr[2] == 12'h000 |->
      a.eff_addr == {(r.opcode[7:0] > IDX_LIMIT) ? ACC_HI_BANK : ACC_LO_BANK, r.opcode[7:0]}
  ) else $error("zero frame pointer changed access bank map");

  chk_dest_select: assert property (
    fire && !is_sub && a.has_dest |=> r.dest_file == $past(r.opcode[9]) &&
      r.eaddr == $past(a.eff_addr)
  ) else $error("destination select or latched address wrong");

  chk_sub_keeps_addr: assert property (
    fire && is_sub |=> r.eaddr == $past(r.eaddr) && r.idx_used == $past(r.idx_used) &&
      r.dest_file == $past(r.dest_file)
  ) else $error("pointer subtract disturbed address state");

  chk_sub_wraps: assert property (
    fire && is_sub && !is_ret |=>
      r.ptr[$past(sel)] + $past(lit) == $past(r.ptr[sel])
  ) else $error("pointer subtract did not wrap in 12 bits");

  chk_ret_flags: assert property (
    fire && is_ret |=> r.ext_op && !r.disabled_op && r.st == EPSIA_NOP
  ) else $error("subtract-and-return status wrong");

  chk_nop_quiet: assert property (
    r.st == EPSIA_NOP && !access_wr |=> r.ptr == $past(r.ptr) &&
      r.pc == $past(r.pc) && r.eaddr == $past(r.eaddr)
  ) else $error("idle second cycle changed state");

  chk_plain_step: assert property (
    fire && !is_sub |=> r.pc == $past(r.pc) + PC_STEP
  ) else $error("pc did not step past plain instruction");

  chk_byte_groups: assert property (
    r.opcode[15:12] >= 4'h1 && r.opcode[15:12] <= 4'h5 |-> a.has_access && a.has_dest
  ) else $error("byte instruction lost its access bit");

  chk_bit_groups: assert property (
    r.opcode[15:12] >= 4'h8 && r.opcode[15:12] <= 4'hb |-> a.has_access &&
      !a.has_dest && a.dest_file
  ) else $error("bit instruction lost its access bit");

  chk_dest_bit: assert property (
    a.has_dest |-> a.dest_file == r.opcode[9]
  ) else $error("destination bit changed meaning");

  chk_idx_needs_ext: assert property (
    a.indexed |-> r.ext_en && !r.opcode[8] && r.opcode[7:0] <= IDX_LIMIT
  ) else $error("indexed mode used while not allowed");

  chk_idx_latched: assert property (
    fire && !is_sub && a.has_access |=> r.idx_used == $past(a.indexed) &&
      r.eaddr == $past(a.eff_addr)
  ) else $error("indexed flag or address not latched");

  // Register bus answers
  chk_unmapped_read: assert property (
    setup && paddr > OFF_EADDR |=> r.pslverr && r.prdata == 32'h00000000
  ) else $error("unmapped access not flagged");

  chk_busy_issue: assert property (
    setup && pwrite && paddr == OFF_INSTR && r.st != EPSIA_IDLE |=> r.pslverr
  ) else $error("issue while busy not flagged");

  chk_refused_kept: assert property (
    access_wr && r.pslverr && paddr == OFF_INSTR |=> r.refused &&
      r.opcode == $past(r.opcode)
  ) else $error("refused issue changed opcode");

  cov_ret: cover property (fire && is_ret ##1 r.st == EPSIA_NOP);
  cov_sub: cover property (fire && is_sub && !is_ret);
  cov_indexed: cover property (fire && a.indexed);
  cov_refused: cover property (access_wr && r.pslverr && paddr == OFF_INSTR);
  cov_disabled: cover property (fire && !r.ext_en && r.opcode[15:8] == SUB_OPC);
endmodule : epsia_top
`default_nettype wire
